//--- hw/adc_seq_pkg.sv
/*
 Shared constants for the converter sequencing control: register offsets,
 writable-bit masks, field positions, reset value and sequencer states.
 Assumes a single 125 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package adc_seq_pkg;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0]  OFF_CON1 = 8'h00;
   localparam logic [7:0]  OFF_CON2 = 8'h04;
   localparam logic [7:0]  OFF_CON3 = 8'h08;
   localparam logic [7:0]  OFF_CHS  = 8'h0c;
   localparam logic [7:0]  OFF_PIN_DIGITAL_MODE = 8'h10;
   localparam logic [7:0]  OFF_SCAN_MASK_BIT = 8'h14;
   localparam logic [1:0]  OFF_BUF_HI = 2'h1;

   // ==========================================================
   // Writable bits per register; all others read zero except CON2 bit 7, the buffer half status
   localparam logic [15:0] MASK_CON1 = 16'h83e7;
   localparam logic [15:0] MASK_CON2 = 16'hf43f;
   localparam logic [15:0] MASK_CON3 = 16'h9f3f;
   localparam logic [15:0] MASK_CHS  = 16'h8f9f;
   localparam logic [15:0] MASK_PIN  = 16'h1c3f;
   localparam logic [15:0] REG_RST   = 16'h0000;

   // ==========================================================
   // Field positions
   localparam int CON1_ON       = 15;
   localparam int CON1_RESULT_FORMAT_LSB = 8;
   localparam int CON1_TRIG_LSB = 5;
   localparam int CON1_ASAM     = 2;
   localparam int CON1_SAMP     = 1;
   localparam int CON1_DONE     = 0;
   localparam int CON2_REF_LSB  = 13;
   localparam int CON2_OFFSET_CALIBRATE   = 12;
   localparam int CON2_SCAN     = 10;
   localparam int CON2_BUFFER_HALF_STATUS     = 7;
   localparam int CON2_SEQUENCES_PER_IRQ_LSB = 2;
   localparam int CON2_BUFFER_SPLIT_MODE     = 1;
   localparam int CON2_ALTERNATE_MUX_MODE     = 0;
   localparam int CON3_CLKSRC   = 15;
   localparam int CON3_AUTO_SAMPLE_TIME_LSB = 8;
   localparam int CON3_DIV_LSB  = 0;
   localparam int CHS_NEGB      = 15;
   localparam int CHS_POSB_LSB  = 8;
   localparam int CHS_NEGA      = 7;
   localparam int CHS_POSA_LSB  = 0;

   // ==========================================================
   // Codes and timing
   localparam logic [2:0]  TRIG_SOFT = 3'h0;
   localparam logic [2:0]  TRIG_AUTO = 3'h7;
   localparam int          TCY_CLKS  = 2;
   localparam logic [3:0]  SCAN_TOP  = 4'hc;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b001,
      ST_SAMPLE  = 3'b010,
      ST_CONVERT = 3'b100
   } seq_state_t;

endpackage : adc_seq_pkg

//--- hw/tad_tick_gen.sv
/*
 Conversion clock period tick generator: one pulse per conversion clock
 period, from the divided system clock or the synchronised RC clock pin.
 Assumes the RC clock is far slower than clk.
*/
`timescale 1ns/1ps
`default_nettype none
module tad_tick_gen
   import adc_seq_pkg::*;
#(
   parameter int DIV_W = 6
)(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // Source selection
   input  wire logic             rc_clk_pin,
   input  wire logic             use_rc,
   input  wire logic [DIV_W-1:0] divider,
   // Tick
   output var  logic             tad_tick
);

   typedef struct packed {
      logic           s1;
      logic           s2;
      logic           s3;
      logic           lvl;
      logic [DIV_W:0] cnt;
      logic           tick;
   } tick_state_t;

   tick_state_t s;
   tick_state_t n;
   logic [DIV_W:0] period_m1;

   // One instruction cycle is two clk periods.
   assign period_m1 = (DIV_W+1)'((int'(divider) + 1) * TCY_CLKS - 1);

   always_comb
   begin
      n      = s;
      n.tick = 1'b0;
      n.s1   = rc_clk_pin;
      n.s2   = s.s1;
      n.s3   = s.s2;
      if (s.s2 == s.s3)
      begin
         n.lvl = s.s3;
      end
      if (use_rc)
      begin
         n.cnt  = '0;
         n.tick = (s.s2 == s.s3) && s.s3 && !s.lvl;
      end
      else if (s.cnt >= period_m1)
      begin
         n.cnt  = '0;
         n.tick = 1'b1;
      end
      else
      begin
         n.cnt = s.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         s <= '0;
      else
         s <= n;
   end

   assign tad_tick = s.tick;

   min_period_a: assert property (@(posedge clk) disable iff (sys_rst)
      (tad_tick && !use_rc && divider == '0) ##1 (!use_rc && divider == '0)
      |-> !tad_tick ##1 tad_tick)
      else $error("System clock tick spacing is not two clocks.");

endmodule : tad_tick_gen
`default_nettype wire

//--- hw/adc_seq_ctrl.sv
/*
 Sequencing control for a 10-bit successive-approximation converter:
 register file on AHB-Lite, sample/convert sequencer, input multiplexer
 selection, channel scan, result buffer and interrupt-rate counting.
 Assumes the converter core answers each conv_start with one conv_done
 pulse on clk, and that all AHB inputs are synchronous to clk.
*/
// The register offsets and the AHB-Lite slave port were decided locally.
// Summary of operation
// - reference code selects supply or external references.
// - calibration grounds inputs and opens all switches.
// - calibration ignores pin config and channel select.
// - scan bit steps mux A through mask.
// - buffer half status shows half being filled.
// - interrupt after every N+1 sequences.
// - buffer mode: two 8-word halves or one.
// - alternate mode: A first, then B, A.
// - clock source bit picks RC or system.
// - auto-sample time is 0 to 31 periods.
// - conversion period is instruction cycle times N+1.
// - instruction cycle is two oscillator periods.
// - negative select picks input 1 or reference.
// - positive code decodes channels, band gap, none.
// - mux B four bits high, A five low.
// - pin config bit sets digital or analog.
// - scan mask bit includes channel in scan.
// - unimplemented bits read zero, ignore writes.
// - auto trigger ends sampling after sample time.
// - results stored in one of four formats.
`timescale 1ns/1ps
`default_nettype none
module adc_seq_ctrl
   import adc_seq_pkg::*;
#(
   parameter int RES_W = 10,
   parameter int DEPTH = 16
)(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // AHB-Lite slave
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output var  logic             hreadyout,
   output var  logic [31:0]      hrdata,
   output var  logic             hresp,
   // Pins
   input  wire logic             rc_clk_pin,
   input  wire logic             ext_trigger_pin,
   // Converter core
   input  wire logic             conv_done,
   input  wire logic [RES_W-1:0] conv_data,
   output var  logic             sample_en,
   output var  logic             conv_start,
   output var  logic             conv_irq,
   // Analog switch control
   output var  logic [15:0]      pos_switch,
   output var  logic             neg_is_an1,
   output var  logic             ref_pos_ext,
   output var  logic             ref_neg_ext,
   output var  logic             inputs_grounded,
   output var  logic             switch_en,
   output var  logic [12:0]      pin_digital
);

   // ==========================================================
   // State
   typedef struct packed {
      logic [15:0]             con1;
      logic [15:0]             con2;
      logic [15:0]             con3;
      logic [15:0]             chs;
      logic [15:0]             pin_digital_mode;
      logic [15:0]             scan_mask_bit;
      logic [DEPTH-1:0][15:0]  rbuf;
      seq_state_t              st;
      logic [4:0]              smp_cnt;
      logic [3:0]              seq_cnt;
      logic [3:0]              wptr;
      logic [3:0]              scan_ch;
      logic                    half;
      logic                    alt_b;
      logic                    use_b;
      logic                    s1;
      logic                    s2;
      logic                    s3;
      logic                    trig_lvl;
      logic                    wr_pend;
      logic [31:0]             wr_addr;
      logic [31:0]             rdata;
      logic                    ready;
      logic                    sample_en;
      logic                    conv_start;
      logic                    irq;
      logic [15:0]             pos_sw;
      logic                    neg_an1;
      logic                    ref_pos;
      logic                    ref_neg;
      logic                    grounded;
      logic                    sw_en;
      logic [12:0]             pin_dig;
   } state_t;

   state_t s;
   state_t n;
   logic   tad_tick;

   // ==========================================================
   // Functions
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] wd,
                                         input logic [15:0] mask);
      return (wd[15:0] & mask) | (old & ~mask);
   endfunction : merge

   function automatic logic [15:0] pos_decode(input logic [4:0] code);
      logic [15:0] r;
      r = '0;
      // Code 13 closes no switch so the input floats; 6 to 9 are reserved.
      if (code <= 5'd5 || (code >= 5'd10 && code <= 5'd12) ||
          code == 5'd14 || code == 5'd15)
      begin
         r[code[3:0]] = 1'b1;
      end
      return r;
   endfunction : pos_decode

   function automatic logic [3:0] next_scan(input logic [12:0] m,
                                            input logic [3:0]  cur);
      logic [3:0] r;
      logic       found;
      logic [4:0] c;
      r     = cur;
      found = 1'b0;
      for (int i = 1; i <= 13; i++)
      begin
         c = 5'(cur) + 5'(i);
         if (c >= 5'd13)
            c = c - 5'd13;
         if (!found && m[c[3:0]])
         begin
            r     = c[3:0];
            found = 1'b1;
         end
      end
      return r;
   endfunction : next_scan

   function automatic logic [15:0] fmt(input logic [1:0]       result_format,
                                       input logic [RES_W-1:0] d);
      logic [15:0] r;
      case (result_format)
         2'b00:   r = {6'h00, d};
         2'b01:   r = {{7{~d[9]}}, d[8:0]};
         2'b10:   r = {d, 6'h00};
         default: r = {~d[9], d[8:0], 6'h00};
      endcase
      return r;
   endfunction : fmt

   // ==========================================================
   // Next state
   always_comb
   begin
      logic       on;
      logic       start_smp;
      logic       trig_edge;
      logic [4:0] pos_code;
      logic [3:0] widx;
      on         = 1'b0;
      start_smp  = 1'b0;
      trig_edge  = 1'b0;
      pos_code   = '0;
      widx       = '0;
      n          = s;
      n.conv_start = 1'b0;
      n.irq        = 1'b0;
      n.ready      = 1'b1;

      // Bus data phase: writes land here, hardware updates below win.
      if (s.wr_pend && s.wr_addr[31:8] == '0)
      begin
         case (s.wr_addr[7:0])
            OFF_CON1: n.con1 = merge(s.con1, hwdata, MASK_CON1);
            OFF_CON2: n.con2 = merge(s.con2, hwdata, MASK_CON2);
            OFF_CON3: n.con3 = merge(s.con3, hwdata, MASK_CON3);
            OFF_CHS:  n.chs  = merge(s.chs,  hwdata, MASK_CHS);
            OFF_PIN_DIGITAL_MODE: n.pin_digital_mode = merge(s.pin_digital_mode, hwdata, MASK_PIN);
            OFF_SCAN_MASK_BIT: n.scan_mask_bit = merge(s.scan_mask_bit, hwdata, MASK_PIN);
            default:  n.con1 = n.con1;
         endcase
      end

      // Trigger pin: three flip-flops, a change counts once two agree.
      n.s1 = ext_trigger_pin;
      n.s2 = s.s1;
      n.s3 = s.s2;
      if (s.s2 == s.s3)
         n.trig_lvl = s.s3;
      trig_edge = (s.s2 == s.s3) && s.s3 && !s.trig_lvl;

      on = n.con1[CON1_ON];
      case (s.st)
         ST_IDLE:
         begin
            if (on && (n.con1[CON1_SAMP] || n.con1[CON1_ASAM]))
               start_smp = 1'b1;
         end
         ST_SAMPLE:
         begin
            if ((n.con1[CON1_TRIG_LSB +: 3] == TRIG_AUTO && tad_tick &&
                 s.smp_cnt == n.con3[CON3_AUTO_SAMPLE_TIME_LSB +: 5]) ||
                (n.con1[CON1_TRIG_LSB +: 3] == TRIG_SOFT && !n.con1[CON1_SAMP]) ||
                (n.con1[CON1_TRIG_LSB +: 3] != TRIG_SOFT &&
                 n.con1[CON1_TRIG_LSB +: 3] != TRIG_AUTO && trig_edge))
            begin
               n.st               = ST_CONVERT;
               n.sample_en        = 1'b0;
               n.con1[CON1_SAMP]  = 1'b0;
               n.conv_start       = 1'b1;
            end
            else if (tad_tick && s.smp_cnt != 5'h1f)
            begin
               n.smp_cnt = s.smp_cnt + 5'd1;
            end
         end
         ST_CONVERT:
         begin
            if (conv_done)
            begin
               widx = n.con2[CON2_BUFFER_SPLIT_MODE] ? {s.half, s.wptr[2:0]} : s.wptr;
               n.rbuf[widx] = fmt(n.con1[CON1_RESULT_FORMAT_LSB +: 2], conv_data);
               n.con1[CON1_DONE] = 1'b1;
               if (s.seq_cnt == n.con2[CON2_SEQUENCES_PER_IRQ_LSB +: 4])
               begin
                  n.irq     = 1'b1;
                  n.seq_cnt = '0;
                  n.wptr    = '0;
                  if (n.con2[CON2_BUFFER_SPLIT_MODE])
                     n.half = ~s.half;
               end
               else
               begin
                  n.seq_cnt = s.seq_cnt + 4'd1;
                  n.wptr    = s.wptr + 4'd1;
               end
               n.alt_b = n.con2[CON2_ALTERNATE_MUX_MODE] & ~s.use_b;
               if (n.con2[CON2_SCAN] && !s.use_b)
                  n.scan_ch = next_scan(n.scan_mask_bit[12:0], s.scan_ch);
               if (n.con1[CON1_ASAM])
                  start_smp = 1'b1;
               else
                  n.st = ST_IDLE;
            end
         end
         default:
         begin
            n.st = ST_IDLE;
         end
      endcase

      if (start_smp)
      begin
         n.st              = ST_SAMPLE;
         n.sample_en       = 1'b1;
         n.con1[CON1_SAMP] = 1'b1;
         n.smp_cnt         = '0;
         n.use_b           = n.con2[CON2_ALTERNATE_MUX_MODE] & n.alt_b;
         if (n.use_b)
            pos_code = {1'b0, n.chs[CHS_POSB_LSB +: 4]};
         else if (n.con2[CON2_SCAN])
            pos_code = {1'b0, n.scan_ch};
         else
            pos_code = n.chs[CHS_POSA_LSB +: 5];
         n.pos_sw  = pos_decode(pos_code);
         n.neg_an1 = n.use_b ? n.chs[CHS_NEGB] : n.chs[CHS_NEGA];
      end

      // Turning the module off resets the sequence to its first sample.
      if (!on)
      begin
         n.st              = ST_IDLE;
         n.sample_en       = 1'b0;
         n.conv_start      = 1'b0;
         n.con1[CON1_SAMP] = 1'b0;
         n.seq_cnt         = '0;
         n.wptr            = '0;
         n.half            = 1'b0;
         n.alt_b           = 1'b0;
         n.use_b           = 1'b0;
         n.scan_ch         = next_scan(n.scan_mask_bit[12:0], SCAN_TOP);
      end

      n.con2[CON2_BUFFER_HALF_STATUS] = n.half;
      n.ref_pos = n.con2[CON2_REF_LSB +: 3] == 3'h1 ||
                  n.con2[CON2_REF_LSB +: 3] == 3'h3;
      n.ref_neg = n.con2[CON2_REF_LSB +: 3] == 3'h2 ||
                  n.con2[CON2_REF_LSB +: 3] == 3'h3;
      // Calibration overrides every input selection, so pin config has no say.
      n.grounded = n.con2[CON2_OFFSET_CALIBRATE];
      n.sw_en    = n.sample_en & ~n.con2[CON2_OFFSET_CALIBRATE];
      n.pin_dig  = n.pin_digital_mode[12:0];

      // Address phase: read data is taken after this cycle's updates, so
      // a read that follows a write sees the new value.
      n.wr_pend = 1'b0;
      if (hsel && hready && htrans[1])
      begin
         n.wr_pend = hwrite;
         n.wr_addr = haddr;
         n.rdata   = '0;
         if (!hwrite && haddr[31:8] == '0)
         begin
            if (haddr[7:6] == OFF_BUF_HI)
               n.rdata = {16'h0000, n.rbuf[haddr[5:2]]};
            else
            begin
               case (haddr[7:0])
                  OFF_CON1: n.rdata = {16'h0000, n.con1};
                  OFF_CON2: n.rdata = {16'h0000, n.con2};
                  OFF_CON3: n.rdata = {16'h0000, n.con3};
                  OFF_CHS:  n.rdata = {16'h0000, n.chs};
                  OFF_PIN_DIGITAL_MODE: n.rdata = {16'h0000, n.pin_digital_mode};
                  OFF_SCAN_MASK_BIT: n.rdata = {16'h0000, n.scan_mask_bit};
                  default:  n.rdata = '0;
               endcase
            end
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s       <= '0;
         s.st    <= ST_IDLE;
         s.ready <= 1'b1;
      end
      else
      begin
         s <= n;
      end
   end

   // ==========================================================
   // Conversion clock period ticks
   tad_tick_gen #(
      .DIV_W (6)
   ) u_tick (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .rc_clk_pin (rc_clk_pin),
      .use_rc     (s.con3[CON3_CLKSRC]),
      .divider    (s.con3[CON3_DIV_LSB +: 6]),
      .tad_tick   (tad_tick)
   );

   assign hreadyout       = s.ready;
   assign hrdata          = s.rdata;
   assign hresp           = 1'b0;
   assign sample_en       = s.sample_en;
   assign conv_start      = s.conv_start;
   assign conv_irq        = s.irq;
   assign pos_switch      = s.pos_sw;
   assign neg_is_an1      = s.neg_an1;
   assign ref_pos_ext     = s.ref_pos;
   assign ref_neg_ext     = s.ref_neg;
   assign inputs_grounded = s.grounded;
   assign switch_en       = s.sw_en;
   assign pin_digital     = s.pin_dig;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   ref_decode_a: assert property (ref_pos_ext == (!s.con2[15] && s.con2[13]))
      else $error("Positive reference select wrong.");
   cal_ground_a: assert property (s.con2[CON2_OFFSET_CALIBRATE] |-> inputs_grounded && !switch_en)
      else $error("Calibration left inputs connected.");
   irq_rate_a: assert property (conv_irq |-> $past(s.seq_cnt) == $past(s.con2[5:2])
      && s.seq_cnt == 4'h0 && s.wptr == 4'h0)
      else $error("Interrupt at wrong sequence count.");
   half_swap_a: assert property (conv_irq && s.con2[CON2_BUFFER_SPLIT_MODE] |->
      s.half != $past(s.half) && s.con2[CON2_BUFFER_HALF_STATUS] == s.half)
      else $error("Buffer half did not swap.");
   alt_mux_a: assert property (s.st == ST_CONVERT && conv_done && s.con2[CON2_ALTERNATE_MUX_MODE]
      && !s.use_b && s.con1[CON1_ASAM] && s.con1[CON1_ON] |=> s.use_b && sample_en)
      else $error("Alternate sample did not use mux B.");
   auto_time_a: assert property (conv_start && s.con1[7:5] == TRIG_AUTO |->
      $past(s.smp_cnt) == $past(s.con3[12:8]) && $past(tad_tick))
      else $error("Auto sample time not honoured.");
   unimpl_zero_a: assert property (((s.con3 & ~MASK_CON3) == 16'h0000) &&
      ((s.chs & ~MASK_CHS) == 16'h0000) && ((s.scan_mask_bit & ~MASK_PIN) == 16'h0000))
      else $error("Unimplemented bit set.");
   scan_pick_a: assert property (sample_en && !$past(sample_en) && s.con2[CON2_SCAN]
      && !s.use_b && s.scan_mask_bit[s.scan_ch] |-> pos_switch[s.scan_ch])
      else $error("Scan channel not selected.");

endmodule : adc_seq_ctrl
`default_nettype wire

//--- verif/conv_core_model.sv
/* Converter core stand-in: answers each start pulse with one done pulse.
   Assumes start is a one-cycle pulse on clk; LAT sets how slowly it answers. */
`timescale 1ns/1ps
`default_nettype none
module conv_core_model #(
   parameter int LAT = 10
)(
   // Core handshake
   input  wire logic       clk,
   input  wire logic       conv_start,
   output var  logic       conv_done,
   output var  logic [9:0] conv_data
);
   int         cnt = 0;
   logic [9:0] res = 10'h200;
   initial conv_done = 1'b0;
   initial conv_data = 10'h155;
   // Data is good only in the done cycle; it toggles otherwise so a late capture shows.
   always @(posedge clk)
   begin
      conv_done <= (cnt == 1);
      conv_data <= (cnt == 1) ? res : ~conv_data;
      if (cnt == 1)
         res <= res + 10'h1;
      if (conv_start)
         cnt <= LAT;
      else if (cnt != 0)
         cnt <= cnt - 1;
   end
endmodule : conv_core_model
`default_nettype wire

//--- verif/adc_sequencing_control_tb.sv
/* Self-checking bench for the converter sequencing control.
   Assumes the core stand-in conv_core_model and zero-wait AHB-Lite answers. */
`timescale 1ns/1ps
`default_nettype none
module adc_sequencing_control_tb import adc_seq_pkg::*;;
   // =====
   // Signals
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        rc_clk_pin = 1'b0;
   logic        hreadyout, hresp, conv_done, conv_start, sample_en, conv_irq;
   logic        neg_is_an1, ref_pos_ext, ref_neg_ext, inputs_grounded, switch_en;
   logic [31:0] hrdata, rd, c2rd;
   logic [9:0]  conv_data;
   logic [15:0] pos_switch, last_sw;
   logic [12:0] pin_digital;
   logic [15:0] ctl1 = 16'h80e4;
   logic [15:0] sw_log[$];
   logic [9:0]  res_q[$];
   int          failures = 0, check_count = 0;
   int          len = 0, last_len = 0, starts = 0, seq_n = 0, irqs = 0, sequences_per_irq = 0;
   int          scan_ch[4] = '{1, 4, 11, 1};
   int          alt_ch[4] = '{2, 3, 2, 3};
   typedef struct {logic [7:0] a; logic [15:0] e;} row_t;
   row_t        rows[6] = '{'{OFF_CON2, 16'hf43f}, '{OFF_CON3, 16'h9f3f},
      '{OFF_CHS, 16'h8f9f}, '{OFF_PIN_DIGITAL_MODE, 16'h1c3f}, '{OFF_SCAN_MASK_BIT, 16'h1c3f}, '{8'h20, 16'h0}};

   adc_seq_ctrl adc_seq_ctrl_inst (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rc_clk_pin(rc_clk_pin),
      .ext_trigger_pin(1'b0), .conv_done(conv_done), .conv_data(conv_data),
      .sample_en(sample_en), .conv_start(conv_start), .conv_irq(conv_irq),
      .pos_switch(pos_switch), .neg_is_an1(neg_is_an1), .ref_pos_ext(ref_pos_ext),
      .ref_neg_ext(ref_neg_ext), .inputs_grounded(inputs_grounded), .switch_en(switch_en),
      .pin_digital(pin_digital));
   conv_core_model conv_core_model_inst (.clk(clk), .conv_start(conv_start),
      .conv_done(conv_done), .conv_data(conv_data));

   initial
   begin
      forever #4 clk = ~clk;
   end
   // The RC clock is free running and unrelated in phase to clk.
   initial
   begin
      #3;
      forever #80 rc_clk_pin = ~rc_clk_pin;
   end

   // =====
   // Checking and bus tasks
   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      n = 0;
      do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
      q = hrdata;
      if (n >= 50)
      begin
         failures++;
         stop_test();
      end
   endtask : bus

   // Upper half written as ones: it must be ignored.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      bus(1'b1, a, {16'hffff, d}, rd);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, rd);
      chk(rd, e);
   endtask : rdc

   function automatic logic [15:0] dec(input logic [4:0] k);
      dec = (k < 6 || (k > 9 && k < 13) || k > 13) ? 16'h1 << k : 16'h0;
   endfunction : dec

   // =====
   // Sequence monitor
   always @(posedge clk)
   begin
      if (sample_en === 1'b1)
      begin
         len++;
         last_sw = pos_switch;
      end
      if (conv_start === 1'b1)
      begin
         sw_log.push_back(last_sw);
         last_len = len;
         len = 0;
         starts++;
      end
      if (conv_done === 1'b1)
      begin
         seq_n++;
         res_q.push_back(conv_data);
      end
      if (conv_irq === 1'b1)
      begin
         chk(seq_n, sequences_per_irq + 1);
         seq_n = 0;
         irqs++;
      end
   end

   // Auto-convert run until n starts or m interrupts, then switch off and drain.
   task automatic run(input logic [15:0] c2, c3, chs, scan_mask_bit, input int n, m);
      int k;
      wr(OFF_CON2, c2);
      wr(OFF_CON3, c3);
      wr(OFF_CHS, chs);
      wr(OFF_SCAN_MASK_BIT, scan_mask_bit);
      sequences_per_irq = int'(c2[5:2]);
      seq_n = 0;
      irqs = 0;
      starts = 0;
      sw_log.delete();
      res_q.delete();
      wr(OFF_CON1, ctl1);
      for (k = 0; k < 20000 && starts < n && irqs < m; k++)
         @(posedge clk);
      bus(1'b0, OFF_CON2, 32'h0, c2rd);
      wr(OFF_CON1, 16'h0);
      if (k == 20000)
      begin
         failures++;
         stop_test();
      end
      repeat (30) @(posedge clk);
   endtask : run

   // =====
   // Main sequence
   initial
   begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      foreach (rows[i])
      begin
         rdc(rows[i].a, 32'h0);
         wr(rows[i].a, 16'hffff);
         rdc(rows[i].a, {16'h0, rows[i].e});
      end
      chk({19'h0, pin_digital}, 32'h1c3f);
      wr(OFF_SCAN_MASK_BIT, 16'h0);
      for (int c = 0; c < 8; c++)
      begin
         logic [2:0] v;
         v = 3'(c);
         wr(OFF_CON2, {v, 13'h0});
         rdc(OFF_CON2, {16'h0, v, 13'h0});
         chk({30'h0, ref_pos_ext, ref_neg_ext}, {30'h0, v[0] & ~v[2], v[1] & ~v[2]});
      end
      wr(OFF_CON2, 16'h0);
      // Selections are latched when sampling starts, so each code gets a fresh sample.
      for (int k = 0; k < 16; k++)
      begin
         if (k == 6 || k == 7)
            continue;
         wr(OFF_CHS, {8'h0, 1'(k), 2'h0, 5'(k)});
         wr(OFF_CON1, 16'h8002);
         rdc(OFF_CHS, {24'h0, 1'(k), 2'h0, 5'(k)});
         chk({14'h0, switch_en, neg_is_an1, pos_switch}, {14'h0, 1'b1, 1'(k), dec(5'(k))});
         wr(OFF_CON1, 16'h8000);
         repeat (14) @(posedge clk);
      end
      // Pins stay digital and a channel stays selected: calibration must not care.
      wr(OFF_CON1, 16'h8002);
      wr(OFF_CON2, 16'h1000);
      rdc(OFF_CON2, 32'h1000);
      chk({30'h0, inputs_grounded, switch_en}, 32'h2);
      wr(OFF_CON2, 16'h0);
      wr(OFF_CON1, 16'h8000);
      repeat (30) @(posedge clk);
      wr(OFF_CON1, 16'h0);
      run(16'h0400, 16'h0201, 16'h0, 16'h0812, 4, 9);
      for (int i = 0; i < 4; i++)
         chk({16'h0, sw_log[i]}, {16'h0, 16'h1 << scan_ch[i]});
      run(16'h0001, 16'h0200, 16'h0302, 16'h0, 4, 9);
      for (int i = 0; i < 4; i++)
         chk({16'h0, sw_log[i]}, {16'h0, 16'h1 << alt_ch[i]});
      run(16'h003c, 16'h0301, 16'h0, 16'h0, 99, 1);
      chk(res_q.size(), 16);
      chk({31'h0, last_len >= 13 && last_len <= 16}, 32'h1);
      rdc(8'h7c, {22'h0, res_q[15]});
      ctl1 = 16'h83e4;
      run(16'h0006, 16'h0201, 16'h0, 16'h0, 99, 1);
      chk({31'h0, c2rd[7]}, 32'h1);
      rdc(8'h44, {16'h0, ~res_q[1][9], res_q[1][8:0], 6'h0});
      run(16'h0, 16'h8301, 16'h0, 16'h0, 2, 9);
      chk({31'h0, last_len >= 61 && last_len <= 80}, 32'h1);
      wr(OFF_CON1, 16'h80e4);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      chk({31'h0, sample_en}, 32'h0);
      rdc(OFF_CON1, 32'h0);
      stop_test();
   end
endmodule : adc_sequencing_control_tb
`default_nettype wire
